//--- src/mpf_pause_fault_ctrl.sv
// mpf_pause_fault_ctrl: receive-side local fault gating and control frame
// classification, plus the transmit pause frame builder.
// assumes lane fault codes, start blocks and beats arrive on clk_sys;
// the receive source may be stalled through rxInReady.
`timescale 1ns/1ps
module mpf_pause_fault_ctrl
  import mpf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  // local fault control and lane events
  input wire logic rxLocalFaultProcessEn,
  input wire logic localFaultIndication,
  input wire logic rxStartBlock,
  output logic rxFaultActive,
  output logic rxWaitStart,
  // receive beats from the lane side
  input wire logic rxInValid,
  output logic rxInReady,
  input wire logic [BEAT_W-1:0] rxInData,
  input wire logic rxInSop,
  input wire logic rxInEop,
  input wire logic rxInErr,
  // user packet bus, receive
  output logic rxOutValid,
  input wire logic rxOutReady,
  output logic [BEAT_W-1:0] rxOutData,
  output logic rxOutSop,
  output logic rxOutEop,
  output logic rxOutErr,
  // receive pause configuration
  input wire logic [47:0] rxPauseUnicastDestAddr,
  input wire logic [47:0] rxPauseMulticastDestAddr,
  input wire logic [47:0] rxPauseSourceAddr,
  input wire logic [15:0] rxGlobalCtrlOpcodeMin,
  input wire logic [15:0] rxGlobalCtrlOpcodeMax,
  input wire logic [15:0] rxGlobalCtrlEthertype,
  input wire logic [15:0] rxPriorityCtrlEthertype,
  input wire logic [15:0] rxPriorityCtrlOpcodeMin,
  input wire logic [15:0] rxPriorityCtrlOpcodeMax,
  input wire logic [15:0] rxGlobalPauseEthertype,
  input wire logic [15:0] rxGlobalPauseOpcode,
  input wire logic [15:0] rxPriorityPauseEthertype,
  input wire logic [15:0] rxPriorityPauseOpcode,
  input wire logic rxCheckAck,
  input wire logic rxForwardControl,
  // pause requests to the user and their acknowledge
  output logic [ACK_W-1:0] rxPauseReq,
  input wire logic [ACK_W-1:0] rxPauseAck,
  // transmit pause configuration
  input wire logic [47:0] txGlobalPauseDestAddr,
  input wire logic [47:0] txGlobalPauseSourceAddr,
  input wire logic [15:0] txGlobalPauseEthertype,
  input wire logic [15:0] txGlobalPauseOpcode,
  input wire logic [47:0] txPriorityPauseDestAddr,
  input wire logic [47:0] txPriorityPauseSourceAddr,
  input wire logic [15:0] txPriorityPauseEthertype,
  input wire logic [15:0] txPriorityPauseOpcode,
  // transmit pause requests and frame output
  input wire logic txGlobalPauseStart,
  input wire logic txPriorityPauseStart,
  input wire logic [15:0] txPauseQuanta,
  input wire logic [7:0] txPauseClassVec,
  output logic txPauseBusy,
  output logic txOutValid,
  input wire logic txOutReady,
  output logic [BEAT_W-1:0] txOutData,
  output logic txOutSop,
  output logic txOutEop
);

  mpf_rx_cfg_t cfg_q, cfg_d;
  mpf_tx_cfg_t txCfg;

  // gather the loose configuration pins into one record
  assign cfg_d = '{
    ucastDa: rxPauseUnicastDestAddr,
    mcastDa: rxPauseMulticastDestAddr,
    srcAddr: rxPauseSourceAddr,
    gcOpMin: rxGlobalCtrlOpcodeMin,
    gcOpMax: rxGlobalCtrlOpcodeMax,
    gcEtype: rxGlobalCtrlEthertype,
    pcEtype: rxPriorityCtrlEthertype,
    pcOpMin: rxPriorityCtrlOpcodeMin,
    pcOpMax: rxPriorityCtrlOpcodeMax,
    gpEtype: rxGlobalPauseEthertype,
    gpOpcode: rxGlobalPauseOpcode,
    ppEtype: rxPriorityPauseEthertype,
    ppOpcode: rxPriorityPauseOpcode,
    faultEn: rxLocalFaultProcessEn,
    checkAck: rxCheckAck,
    fwdCtrl: rxForwardControl};

  assign txCfg = '{
    gpDa: txGlobalPauseDestAddr,
    gpSa: txGlobalPauseSourceAddr,
    ppDa: txPriorityPauseDestAddr,
    ppSa: txPriorityPauseSourceAddr,
    gpEtype: txGlobalPauseEthertype,
    gpOpcode: txGlobalPauseOpcode,
    ppEtype: txPriorityPauseEthertype,
    ppOpcode: txPriorityPauseOpcode};

  // held copy of the config, defaults apply from reset until the
  // first edge after release; pins take effect one cycle late
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= RX_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // header fields of the current beat, only meaningful on a start beat
  logic [47:0] hdrDa, hdrSa;
  logic [15:0] hdrEt, hdrOp;
  assign hdrDa = rxInData[DA_LO +: 48];
  assign hdrSa = rxInData[SA_LO +: 48];
  assign hdrEt = rxInData[ET_LO +: 16];
  assign hdrOp = rxInData[OP_LO +: 16];

  // frame classification
  logic daHit, saOk, gcpHit, pcpHit, gppHit, pppHit, isCtrl, ctrlDrop;
  assign daHit = (hdrDa == cfg_q.ucastDa) | (hdrDa == cfg_q.mcastDa);
  // a zero source address means any sender is accepted
  assign saOk = (cfg_q.srcAddr == ADDR_ZERO) | (hdrSa == cfg_q.srcAddr);
  assign gcpHit = daHit & (hdrEt == cfg_q.gcEtype)
    & mpf_in_range(hdrOp, cfg_q.gcOpMin, cfg_q.gcOpMax);
  assign pcpHit = daHit & (hdrEt == cfg_q.pcEtype)
    & mpf_in_range(hdrOp, cfg_q.pcOpMin, cfg_q.pcOpMax);
  assign gppHit = daHit & (hdrEt == cfg_q.gpEtype) & (hdrOp == cfg_q.gpOpcode);
  assign pppHit = daHit & (hdrEt == cfg_q.ppEtype) & (hdrOp == cfg_q.ppOpcode);
  assign isCtrl = gcpHit | pcpHit | gppHit | pppHit;
  assign ctrlDrop = isCtrl & ~cfg_q.fwdCtrl;

  // local fault gating
  logic faultRaw, blocked;
  logic waitStart_q, faultSeen_q;
  assign faultRaw = cfg_q.faultEn & localFaultIndication;
  assign blocked = faultRaw | waitStart_q;
  assign rxFaultActive = faultSeen_q;
  assign rxWaitStart = waitStart_q;

  // the wait for a start block is armed for the whole fault and only
  // a start block seen after the fault has gone releases it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      waitStart_q <= 1'b0;
      faultSeen_q <= 1'b0;
    end else begin
      waitStart_q <= faultRaw | (waitStart_q & ~rxStartBlock);
      faultSeen_q <= faultRaw;
    end
  end

  // packet tracking
  logic inPkt_q, dropPkt_q, pendGp_q, pendPp_q, termPend_q;
  logic rxFire, acceptSop, acceptMid, fwdBeat, pktEnd, gpDone, ppDone;
  logic bufInValid, bufInReady;
  logic [BUF_W-1:0] bufInData, bufOutData, termBeat;

  // while blocked, beats are swallowed rather than stalled, since the
  // lanes cannot be held back during a fault; a pending cut-off beat
  // stalls the source so it is never lost
  assign rxInReady = blocked | (bufInReady & ~termPend_q);
  assign rxFire = rxInValid & rxInReady;
  assign acceptSop = rxFire & ~blocked & rxInSop;
  // body beats that follow no accepted start are orphans and dropped
  assign acceptMid = rxFire & ~blocked & ~rxInSop & inPkt_q;
  assign fwdBeat = (acceptSop & ~ctrlDrop) | (acceptMid & ~dropPkt_q);
  assign pktEnd = (acceptSop | acceptMid) & rxInEop;
  assign gpDone = pktEnd & (rxInSop ? (gppHit & saOk) : pendGp_q);
  assign ppDone = pktEnd & (rxInSop ? (pppHit & saOk) : pendPp_q);

  // cut-off beat: end of packet with the error bit set
  always_comb begin
    termBeat = '0;
    termBeat[BUF_EOP] = 1'b1;
    termBeat[BUF_ERR] = 1'b1;
  end

  assign bufInValid = termPend_q | fwdBeat;
  assign bufInData = termPend_q ? termBeat : {rxInSop, rxInEop, rxInErr, rxInData};

  // a fault hitting a forwarded packet arms the cut-off; the set wins
  // over the clear so a second fault is never lost
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      termPend_q <= 1'b0;
    end else begin
      termPend_q <= (faultRaw & inPkt_q & ~dropPkt_q) | (termPend_q & ~bufInReady);
    end
  end

  // packet state: a fault drops the packet in flight
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      inPkt_q <= 1'b0;
      dropPkt_q <= 1'b0;
    end else if (faultRaw) begin
      inPkt_q <= 1'b0;
      dropPkt_q <= 1'b0;
    end else if (acceptSop) begin
      inPkt_q <= ~rxInEop;
      dropPkt_q <= ctrlDrop;
    end else if (pktEnd) begin
      inPkt_q <= 1'b0;
      dropPkt_q <= 1'b0;
    end
  end

  // pause kind remembered from the header until the frame ends
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pendGp_q <= 1'b0;
      pendPp_q <= 1'b0;
    end else if (faultRaw || pktEnd) begin
      pendGp_q <= 1'b0;
      pendPp_q <= 1'b0;
    end else if (acceptSop) begin
      pendGp_q <= gppHit & saOk;
      pendPp_q <= pppHit & saOk;
    end
  end

  // pause requests: with acknowledge checking a bit stands until acked,
  // a new event wins over an ack in the same cycle; without it the
  // request is a one-cycle pulse and the ack bus is not looked at
  logic [ACK_W-1:0] pauseReq_q, pauseEv, pauseReq_d;
  assign pauseEv = {gpDone, ppDone ? ALL_CLASSES : 8'h00};
  assign pauseReq_d = cfg_q.checkAck ? (pauseEv | (pauseReq_q & ~rxPauseAck)) : pauseEv;
  assign rxPauseReq = pauseReq_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pauseReq_q <= 9'h000;
    end else begin
      pauseReq_q <= pauseReq_d;
    end
  end

  // two-entry buffer so a stalled user loses no beat
  mpf_two_entry_buf #(
    .W(BUF_W),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inData(bufInData),
    .outValid(rxOutValid),
    .outReady(rxOutReady),
    .outData(bufOutData)
  );

  assign rxOutData = bufOutData[BEAT_W-1:0];
  assign rxOutSop = bufOutData[BUF_SOP];
  assign rxOutEop = bufOutData[BUF_EOP];
  assign rxOutErr = bufOutData[BUF_ERR];

  // transmit pause frame builder
  mpf_pause_frame_gen u_tx_gen (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cfg(txCfg),
    .startGlobal(txGlobalPauseStart),
    .startPriority(txPriorityPauseStart),
    .quanta(txPauseQuanta),
    .classVec(txPauseClassVec),
    .busy(txPauseBusy),
    .outValid(txOutValid),
    .outReady(txOutReady),
    .outData(txOutData),
    .outSop(txOutSop),
    .outEop(txOutEop)
  );

  // checks on the receive side
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_fault_seen: assert property (
    cfg_q.faultEn && localFaultIndication |=> rxFaultActive && rxWaitStart)
    else $error("enabled local fault not acted on");

  a_fault_ignored: assert property (
    !cfg_q.faultEn && !waitStart_q |-> !blocked ##1 !rxFaultActive)
    else $error("local fault acted on while disabled");

  a_fault_blocks: assert property (
    faultRaw |-> !fwdBeat ##1 !inPkt_q)
    else $error("packet accepted during local fault");

  a_cut_error: assert property (
    faultRaw && inPkt_q && !dropPkt_q |=> termPend_q ##0
    (!bufInReady || (bufInValid && bufInData[BUF_EOP] && bufInData[BUF_ERR])))
    else $error("packet in flight not cut off with error");

  a_start_wait: assert property (
    $fell(faultRaw) && !rxStartBlock |-> waitStart_q && !fwdBeat)
    else $error("packet delivered before start block");

  a_opcode_range: assert property (
    gcpHit |-> hdrOp >= cfg_q.gcOpMin && hdrOp <= cfg_q.gcOpMax && daHit)
    else $error("global control opcode outside window");

  a_ctrl_drop: assert property (
    acceptSop && isCtrl && !cfg_q.fwdCtrl && !rxInEop && !faultRaw |->
    !bufInValid ##1 dropPkt_q)
    else $error("control frame forwarded while forwarding off");

  a_da_gate: assert property (
    acceptSop && !daHit |-> !gpDone && !ppDone)
    else $error("pause raised for foreign destination");

  a_gpp_raise: assert property (
    acceptSop && rxInEop && gppHit && saOk |=> rxPauseReq[ACK_GLOBAL])
    else $error("global pause frame raised no request");

  a_ack_hold: assert property (
    cfg_q.checkAck && rxPauseReq[ACK_GLOBAL] && !rxPauseAck[ACK_GLOBAL]
    |=> rxPauseReq[ACK_GLOBAL])
    else $error("pause request dropped before acknowledge");

  a_prio_raise: assert property (
    acceptSop && rxInEop && pppHit && saOk |=> rxPauseReq[7:0] == ALL_CLASSES)
    else $error("priority pause raised no request");

  a_req_pulse: assert property (
    !cfg_q.checkAck && !gpDone |=> !rxPauseReq[ACK_GLOBAL])
    else $error("pause request stood without ack checking");

  a_ack_release: assert property (
    cfg_q.checkAck && rxPauseAck[ACK_GLOBAL] && !gpDone |=> !rxPauseReq[ACK_GLOBAL])
    else $error("acked pause request not released");

  a_start_release: assert property (
    waitStart_q && !faultRaw && rxStartBlock |=> !rxWaitStart)
    else $error("start block did not release receiver");

endmodule // mpf_pause_fault_ctrl

//--- src/mpf_pkg.sv
// mpf_pkg: constants, header layout and config types of the pause and
// local fault control block.
// assumes one beat of BEAT_W bits holds the whole frame header.
// Functional notes
// - fault handling on: act on local fault codes
// - fault handling off by default: ignore fault codes
// - no packets accepted while fault present
// - packet in flight cut short, error flagged
// - after fault, wait for start block
// - unicast pause address held, default zero
// - multicast pause address held, reserved default
// - pause source address held, default zero
// - global control opcode within min and max
// - global control ethertype configurable, default 8808
// - priority control opcode within min and max
// - priority control ethertype configurable, default 8808
// - global pause needs ethertype and opcode match
// - priority pause needs ethertype and opcode match
// - optional wait on nine-bit acknowledge bus
// - control frames forwarded or dropped by option
// - sent global pause destination configurable
// - sent global pause source configurable
// - sent global pause ethertype and opcode configurable
// - sent priority pause destination configurable
// - sent priority pause source configurable
// - sent priority pause ethertype and opcode configurable

package mpf_pkg;
  localparam int BEAT_W = 128;
  localparam int ACK_W = 9;
  localparam int ACK_GLOBAL = 8;
  // header layout inside the first beat
  localparam int DA_LO = 80;
  localparam int SA_LO = 32;
  localparam int ET_LO = 16;
  localparam int OP_LO = 0;
  // sideband bits stacked above the beat in the buffer
  localparam int BUF_ERR = BEAT_W;
  localparam int BUF_EOP = BEAT_W + 1;
  localparam int BUF_SOP = BEAT_W + 2;
  localparam int BUF_W = BEAT_W + 3;
  localparam int BUF_DEPTH = 2;
  localparam logic [47:0] ADDR_ZERO = 48'h0000_0000_0000;
  localparam logic [47:0] PAUSE_MCAST = 48'h0180_c200_0001;
  localparam logic [15:0] MAC_CTRL_ETYPE = 16'h8808;
  localparam logic [15:0] OPCODE_MIN_RESET = 16'h0000;
  localparam logic [15:0] OPCODE_MAX_RESET = 16'hffff;
  localparam logic [15:0] GLOBAL_PAUSE_OP = 16'h0001;
  localparam logic [15:0] PRIO_PAUSE_OP = 16'h0101;
  localparam logic [7:0] ALL_CLASSES = 8'hff;

  typedef struct packed {
    logic [47:0] ucastDa, mcastDa, srcAddr;
    logic [15:0] gcOpMin, gcOpMax, gcEtype, pcEtype, pcOpMin, pcOpMax;
    logic [15:0] gpEtype, gpOpcode, ppEtype, ppOpcode;
    logic faultEn, checkAck, fwdCtrl;
  } mpf_rx_cfg_t;

  localparam mpf_rx_cfg_t RX_CFG_RESET = '{
    ucastDa: ADDR_ZERO, mcastDa: PAUSE_MCAST, srcAddr: ADDR_ZERO,
    gcOpMin: OPCODE_MIN_RESET, gcOpMax: OPCODE_MAX_RESET, gcEtype: MAC_CTRL_ETYPE,
    pcEtype: MAC_CTRL_ETYPE, pcOpMin: OPCODE_MIN_RESET, pcOpMax: OPCODE_MAX_RESET,
    gpEtype: MAC_CTRL_ETYPE, gpOpcode: GLOBAL_PAUSE_OP,
    ppEtype: MAC_CTRL_ETYPE, ppOpcode: PRIO_PAUSE_OP,
    faultEn: 1'b0, checkAck: 1'b1, fwdCtrl: 1'b0};

  typedef struct packed {
    logic [47:0] gpDa, gpSa, ppDa, ppSa;
    logic [15:0] gpEtype, gpOpcode, ppEtype, ppOpcode;
  } mpf_tx_cfg_t;

  localparam mpf_tx_cfg_t TX_CFG_RESET = '{
    gpDa: PAUSE_MCAST, gpSa: ADDR_ZERO, ppDa: PAUSE_MCAST, ppSa: ADDR_ZERO,
    gpEtype: MAC_CTRL_ETYPE, gpOpcode: GLOBAL_PAUSE_OP,
    ppEtype: MAC_CTRL_ETYPE, ppOpcode: PRIO_PAUSE_OP};

  // opcode window test, shared by both control classes
  function automatic logic mpf_in_range(logic [15:0] v, logic [15:0] lo, logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction
endpackage

//--- src/mpf_two_entry_buf.sv
// mpf_two_entry_buf: small flop fifo with valid and ready on both sides.
// assumes the writer honours inReady; storage is flops, read data muxed.
`timescale 1ns/1ps
module mpf_two_entry_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wrPtr_q, rdPtr_q;
  logic [CW-1:0] count_q;
  logic push, pop;

  // full and empty come straight from the occupancy count
  assign inReady = count_q != CW'(DEPTH);
  assign outValid = count_q != '0;
  assign outData = mem_q[rdPtr_q];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= push ? ((wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_q <= pop ? ((rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1) : rdPtr_q;
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
endmodule // mpf_two_entry_buf

//--- src/mpf_pause_frame_gen.sv
// mpf_pause_frame_gen: builds two-beat global or priority pause frames.
// assumes the user holds outReady low to stall; starts while busy are dropped.
`timescale 1ns/1ps
module mpf_pause_frame_gen
  import mpf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire mpf_tx_cfg_t cfg,
  input wire logic startGlobal,
  input wire logic startPriority,
  input wire logic [15:0] quanta,
  input wire logic [7:0] classVec,
  output logic busy,
  output logic outValid,
  input wire logic outReady,
  output logic [BEAT_W-1:0] outData,
  output logic outSop,
  output logic outEop
);
  typedef enum logic [2:0] {
    GEN_IDLE = 3'b001, GEN_HDR = 3'b010, GEN_BODY = 3'b100
  } mpf_gen_state_t;
  mpf_gen_state_t state_q, state_d;
  mpf_tx_cfg_t cfg_q;
  logic [BEAT_W-1:0] data_q, body_q, hdrG, hdrP, bodyG, bodyP;
  logic start;

  // header and body templates; global wins when both starts coincide
  assign hdrG = {cfg_q.gpDa, cfg_q.gpSa, cfg_q.gpEtype, cfg_q.gpOpcode};
  assign hdrP = {cfg_q.ppDa, cfg_q.ppSa, cfg_q.ppEtype, cfg_q.ppOpcode};
  assign bodyG = {quanta, {(BEAT_W-16){1'b0}}};
  assign bodyP = {8'h00, classVec, quanta, {(BEAT_W-32){1'b0}}};
  assign start = (state_q == GEN_IDLE) & (startGlobal | startPriority);
  assign busy = state_q != GEN_IDLE;
  assign outValid = busy;
  assign outSop = state_q == GEN_HDR;
  assign outEop = state_q == GEN_BODY;
  assign outData = data_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      GEN_IDLE: if (start) state_d = GEN_HDR;
      GEN_HDR: if (outReady) state_d = GEN_BODY;
      GEN_BODY: if (outReady) state_d = GEN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= GEN_IDLE;
      cfg_q <= TX_CFG_RESET;
      data_q <= '0;
      body_q <= '0;
    end else begin
      state_q <= state_d;
      cfg_q <= cfg;
      if (start) begin
        data_q <= startGlobal ? hdrG : hdrP;
        body_q <= startGlobal ? bodyG : bodyP;
      end else if (outSop && outReady) begin
        data_q <= body_q;
      end
    end
  end

  a_tx_global_hdr: assert property (@(posedge clk_sys) disable iff (!rstn)
    start && startGlobal |=> outSop && outData == $past(hdrG))
    else $error("global pause header does not carry configured fields");
  a_tx_prio_hdr: assert property (@(posedge clk_sys) disable iff (!rstn)
    start && !startGlobal |=> outSop && outData[15:0] == $past(cfg_q.ppOpcode))
    else $error("priority pause header opcode wrong");
endmodule // mpf_pause_frame_gen

//--- verification/mpf_user_model.sv
// mpf_user_model: user packet logic that sits on the receive packet bus.
// assumes one clk_sys domain; it counts delivered beats and echoes pause acks.
`timescale 1ns/1ps
module mpf_user_model
  import mpf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic stall,
  input wire logic ackOn,
  input wire logic rxOutValid,
  output logic rxOutReady,
  input wire logic [BEAT_W-1:0] rxOutData,
  input wire logic rxOutErr,
  input wire logic [ACK_W-1:0] rxPauseReq,
  output logic [ACK_W-1:0] rxPauseAck,
  output int beats,
  output logic [BEAT_W-1:0] lastData,
  output logic lastErr
);
  // a stall holds ready low, so the buffer has to keep every word meanwhile
  assign rxOutReady = !stall;
  // take each beat; answer a pause request one cycle late when allowed
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      beats <= 0;
      lastData <= '0;
      lastErr <= 1'b0;
      rxPauseAck <= '0;
    end else begin
      rxPauseAck <= ackOn ? rxPauseReq : '0;
      if (rxOutValid && rxOutReady) begin
        beats <= beats + 1;
        lastData <= rxOutData;
        lastErr <= rxOutErr;
      end
    end
  end
endmodule // mpf_user_model

//--- verification/mpf_pause_fault_ctrl_test.sv
// mpf_pause_fault_ctrl_test: directed scenarios for the pause and fault block.
// assumes mpf_pkg and the user model are compiled first.
`timescale 1ns/1ps
module mpf_pause_fault_ctrl_test;
  import mpf_pkg::*;
  logic clk_sys = 0, rstn = 0, local_fault_indication = 0, startBlk = 0, inV = 0, inS = 0, inE = 0;
  logic stall = 0, ackOn = 0, gStart = 0, pStart = 0, rxInReady, txOutValid, txOutSop;
  logic [BEAT_W-1:0] inD = '0, txOutData, lastData;
  logic [ACK_W-1:0] rxPauseReq, rxPauseAck;
  logic lastErr, rxOutValid, rxOutReady, rxOutErr;
  logic faultAct, waitSt;
  logic [BEAT_W-1:0] rxOutData;
  mpf_rx_cfg_t rc = RX_CFG_RESET;
  mpf_tx_cfg_t tc = TX_CFG_RESET;
  int beats, fails = 0, tests_run = 0, n;
  always #4 clk_sys = !clk_sys;
  mpf_pause_fault_ctrl u_mpf_pause_fault_ctrl (.clk_sys(clk_sys), .rstn(rstn),
    .rxLocalFaultProcessEn(rc.faultEn), .localFaultIndication(local_fault_indication), .rxStartBlock(startBlk),
    .rxFaultActive(faultAct), .rxWaitStart(waitSt), .rxInValid(inV),
    .rxInReady(rxInReady), .rxInData(inD),
    .rxInSop(inS), .rxInEop(inE), .rxInErr(1'b0), .rxOutValid(rxOutValid),
    .rxOutReady(rxOutReady), .rxOutData(rxOutData), .rxOutSop(), .rxOutEop(),
    .rxOutErr(rxOutErr), .rxPauseUnicastDestAddr(rc.ucastDa),
    .rxPauseMulticastDestAddr(rc.mcastDa), .rxPauseSourceAddr(rc.srcAddr),
    .rxGlobalCtrlOpcodeMin(rc.gcOpMin), .rxGlobalCtrlOpcodeMax(rc.gcOpMax),
    .rxGlobalCtrlEthertype(rc.gcEtype), .rxPriorityCtrlEthertype(rc.pcEtype),
    .rxPriorityCtrlOpcodeMin(rc.pcOpMin), .rxPriorityCtrlOpcodeMax(rc.pcOpMax),
    .rxGlobalPauseEthertype(rc.gpEtype), .rxGlobalPauseOpcode(rc.gpOpcode),
    .rxPriorityPauseEthertype(rc.ppEtype), .rxPriorityPauseOpcode(rc.ppOpcode),
    .rxCheckAck(rc.checkAck), .rxForwardControl(rc.fwdCtrl), .rxPauseReq(rxPauseReq),
    .rxPauseAck(rxPauseAck), .txGlobalPauseDestAddr(tc.gpDa),
    .txGlobalPauseSourceAddr(tc.gpSa), .txGlobalPauseEthertype(tc.gpEtype),
    .txGlobalPauseOpcode(tc.gpOpcode), .txPriorityPauseDestAddr(tc.ppDa),
    .txPriorityPauseSourceAddr(tc.ppSa), .txPriorityPauseEthertype(tc.ppEtype),
    .txPriorityPauseOpcode(tc.ppOpcode), .txGlobalPauseStart(gStart),
    .txPriorityPauseStart(pStart), .txPauseQuanta(16'h0010), .txPauseClassVec(8'ha5),
    .txPauseBusy(), .txOutValid(txOutValid), .txOutReady(1'b1), .txOutData(txOutData),
    .txOutSop(txOutSop), .txOutEop());
  mpf_user_model u_mpf_user_model (.clk_sys(clk_sys), .rstn(rstn), .stall(stall),
    .ackOn(ackOn), .rxOutValid(rxOutValid), .rxOutReady(rxOutReady), .rxOutData(rxOutData),
    .rxOutErr(rxOutErr), .rxPauseReq(rxPauseReq), .rxPauseAck(rxPauseAck), .beats(beats),
    .lastData(lastData), .lastErr(lastErr));
  // data compare; case equality so an unknown never matches
  task automatic chk(logic [127:0] got, logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  // delivered beat count compare
  task automatic chkN(int got, int exp);
    tests_run++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH %0t beats got %0d exp %0d", $time, got, exp);
    end
  endtask
  // one lane beat, held until the design takes it
  task automatic beat(logic [127:0] d, logic s, logic e);
    @(negedge clk_sys);
    inV = 1;
    inD = d;
    inS = s;
    inE = e;
    @(posedge clk_sys);
    while (rxInReady !== 1'b1) @(posedge clk_sys);
  endtask
  // single-beat packet, then idle long enough for the output to settle
  task automatic pkt(logic [47:0] da, logic [15:0] et, logic [15:0] op);
    n = beats;
    beat({da, 48'h1234_5678_9abc, et, op}, 1, 1);
    @(negedge clk_sys) inV = 0;
    repeat (4) @(negedge clk_sys);
  endtask
  // a pause frame to a foreign address is ordinary traffic
  task automatic t_fwd;
    pkt(48'h0a0b_0c0d_0e0f, 16'h8808, 16'h0001);
    chkN(beats - n, 1);
    chk(lastData, {48'h0a0b_0c0d_0e0f, 48'h1234_5678_9abc, 32'h8808_0001});
    chk(rxPauseReq, 9'h000);
    stall = 1;
    beat({48'h0a0b_0c0d_0e0f, 80'h1}, 1, 1);
    pkt(48'h0a0b_0c0d_0e0f, 16'h0800, 16'h0002);
    stall = 0;
    repeat (4) @(negedge clk_sys);
    chkN(beats - n, 2);
  endtask
  // global, priority and unicast pause: dropped, request held until acked
  task automatic t_pause;
    for (int i = 0; i < 3; i++) begin
      ackOn = 0;
      if (i == 2) rc.ucastDa = 48'h0200_0000_00aa;
      pkt(i == 2 ? 48'h0200_0000_00aa : 48'h0180_c200_0001, 16'h8808,
          i == 1 ? 16'h0101 : 16'h0001);
      chkN(beats - n, 0);
      chk(rxPauseReq, i == 1 ? 9'h0ff : 9'h100);
      @(negedge clk_sys) ackOn = 1;
      repeat (4) @(negedge clk_sys);
      chk(rxPauseReq, 9'h000);
    end
    rc.fwdCtrl = 1;
    rc.checkAck = 0;
    ackOn = 0;
    pkt(48'h0180_c200_0001, 16'h8808, 16'h0001);
    chkN(beats - n, 1);
    chk(rxPauseReq, 9'h000);
    rc = RX_CFG_RESET;
  endtask
  // opcodes above both control windows are no longer control frames
  task automatic t_range;
    rc.gcOpMax = 16'h0001;
    rc.pcOpMax = 16'h0001;
    pkt(48'h0180_c200_0001, 16'h8808, 16'h0002);
    chkN(beats - n, 1);
    rc.gcEtype = 16'h9000;
    rc.pcEtype = 16'h9000;
    rc.gcOpMax = 16'hffff;
    rc.pcOpMax = 16'hffff;
    pkt(48'h0180_c200_0001, 16'h8808, 16'h0002);
    chkN(beats - n, 1);
    rc = RX_CFG_RESET;
  endtask
  // fault cuts a packet, blocks traffic, then waits for a start block
  task automatic t_fault;
    rc.faultEn = 1;
    beat(128'h0, 1, 0);
    @(negedge clk_sys) inV = 0;
    local_fault_indication = 1;
    repeat (5) @(negedge clk_sys);
    chk(lastErr, 1'b1);
    chk({faultAct, waitSt}, 2'b11);
    pkt(48'h0a0b_0c0d_0e0f, 16'h0800, 16'h0000);
    chkN(beats - n, 0);
    local_fault_indication = 0;
    pkt(48'h0a0b_0c0d_0e0f, 16'h0800, 16'h0000);
    chkN(beats - n, 0);
    chk({faultAct, waitSt}, 2'b01);
    startBlk = 1;
    @(negedge clk_sys) startBlk = 0;
    pkt(48'h0a0b_0c0d_0e0f, 16'h0800, 16'h0000);
    chkN(beats - n, 1);
    rc.faultEn = 0;
    @(negedge clk_sys) local_fault_indication = 1;
    repeat (2) @(negedge clk_sys);
    pkt(48'h0a0b_0c0d_0e0f, 16'h0800, 16'h0000);
    chkN(beats - n, 1);
    local_fault_indication = 0;
  endtask
  // global, priority, then a reconfigured global pause frame
  task automatic t_tx;
    for (int i = 0; i < 3; i++) begin
      if (i == 2) tc.gpSa = 48'h0000_3333_4444;
      if (i == 2) tc.gpOpcode = 16'h0002;
      @(negedge clk_sys) gStart = (i != 1);
      pStart = (i == 1);
      @(negedge clk_sys) gStart = 0;
      pStart = 0;
      for (int k = 0; k < 4 && !(txOutValid === 1'b1 && txOutSop === 1'b1); k++)
        @(negedge clk_sys);
      chk(txOutData, {48'h0180_c200_0001, i == 2 ? 48'h0000_3333_4444 : 48'h0000_0000_0000,
        16'h8808, i == 1 ? 16'h0101 : (i == 2 ? 16'h0002 : 16'h0001)});
      @(negedge clk_sys);
      chk(txOutData, i == 1 ? {16'h00a5, 16'h0010, 96'h0} : {16'h0010, 112'h0});
      repeat (3) @(negedge clk_sys);
    end
  endtask
  task automatic print_verdict;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1;
    t_fwd;
    t_pause;
    t_range;
    t_fault;
    t_tx;
    print_verdict;
  end
endmodule // mpf_pause_fault_ctrl_test
